// file: hw/hub_route_top.sv
`timescale 1ns/1ps
module hub_route_top (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic bus_reset,
    input wire logic resume_done,
    input wire logic up_hs_conn,
    input wire logic bit_tick,
    input wire logic sof_det,
    input wire logic hub_suspended,
    input wire logic up_sop,
    input wire logic up_eop,
    input wire logic up_resume,
    input wire logic [hub_route_pkg::NPORTS-1:0] dn_connected,
    input wire logic [hub_route_pkg::NPORTS-1:0] dn_hs_dev,
    input wire logic [hub_route_pkg::NPORTS-1:0] dn_enabled,
    input wire logic [hub_route_pkg::NPORTS-1:0] dn_suspended,
    input wire logic [hub_route_pkg::NPORTS-1:0] dn_sop,
    input wire logic [hub_route_pkg::NPORTS-1:0] dn_eop,
    input wire logic [hub_route_pkg::NPORTS-1:0] dn_resume,
    input wire logic ctrl_wait,
    input wire logic ctrl_pkt_rx,
    output logic hs_mode_q,
    output logic hs_rpt_en_q,
    output logic fs_rpt_en_q,
    output logic tt_en_q,
    output logic [hub_route_pkg::NPORTS-1:0] route_tt_q,
    output logic [hub_route_pkg::NPORTS-1:0] route_rpt_q,
    output logic up_drive_q,
    output logic [hub_route_pkg::NPORTS-1:0] dn_drive_q,
    output logic up_rx_mode_q,
    output logic [hub_route_pkg::NPORTS-1:0] dn_rx_mode_q,
    output logic [3:0] conn_state_q,
    output logic [hub_route_pkg::PIDX_W-1:0] src_port_q,
    output logic frame_locked_q,
    output logic eof_q,
    output logic [hub_route_pkg::NPORTS-1:0] babble_q,
    output logic ctrl_timeout_q
);
    import hub_route_pkg::*;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------

    conn_state_e state_q;
    conn_state_e state_d;
    logic [NPORTS-1:0] live_mask;
    logic [NPORTS-1:0] rpt_live;
    logic [NPORTS-1:0] sop_hit;
    logic [NPORTS-1:0] rsm_src;
    logic [PIDX_W-1:0] sop_idx;
    logic [15:0] ctrl_cnt_q;
    logic ctrl_armed_q;
    logic resync;
    logic cut_babble;

    // lowest set bit of a port mask, used for source choice
    function automatic logic [PIDX_W-1:0] lowest_idx(input logic [NPORTS-1:0] m);
        lowest_idx = '0;
        for (int i = NPORTS - 1; i >= 0; i--) begin
            if (m[i]) begin
                lowest_idx = PIDX_W'(i);
            end
        end
    endfunction

    // ports that may carry signaling through the repeater
    function automatic logic [NPORTS-1:0] rpt_ports(
        input logic [NPORTS-1:0] live,
        input logic [NPORTS-1:0] rpt
    );
        rpt_ports = live & rpt;
    endfunction

    // enabled means enabled and not selectively suspended
    assign live_mask = dn_enabled & ~dn_suspended;
    assign rpt_live = rpt_ports(live_mask, route_rpt_q);
    assign sop_hit = dn_sop & rpt_live;
    assign sop_idx = lowest_idx(sop_hit);
    // resume may start from an enabled or a selectively suspended port
    assign rsm_src = dn_resume & dn_enabled;
    assign resync = bus_reset || resume_done;
    // babble cut only while repeating and the source is repeater-routed
    assign cut_babble = (state_q == ST_UPSTR) && eof_q
        && route_rpt_q[src_port_q] && !route_tt_q[src_port_q];

    // ------------------------------------------------------------
    // speed selection and routing
    // ------------------------------------------------------------

    // speed follows the upstream link; fs_rpt_en_q is off at high speed, hs_rpt_en_q and tt_en_q at full speed
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            hs_mode_q <= 1'b0;
            hs_rpt_en_q <= 1'b0;
            fs_rpt_en_q <= 1'b1;
            tt_en_q <= 1'b0;
        end else begin
            hs_mode_q <= up_hs_conn;
            hs_rpt_en_q <= up_hs_conn;
            fs_rpt_en_q <= !up_hs_conn;
            tt_en_q <= up_hs_conn;
        end
    end

    // per-port routing; speed is taken from the live upstream link so
    // routing and mode change in the same cycle
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            route_tt_q <= '0;
            route_rpt_q <= '0;
        end else if (up_hs_conn) begin
            route_tt_q <= dn_connected & ~dn_hs_dev;
            route_rpt_q <= dn_connected & dn_hs_dev;
        end else begin
            route_tt_q <= '0;
            route_rpt_q <= dn_connected;
        end
    end

    // ------------------------------------------------------------
    // connectivity state machine
    // ------------------------------------------------------------

    // upstream packets win a tie with downstream starts, since the
    // host owns the bus schedule
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (hub_suspended) begin
                    if (up_resume || (rsm_src != '0)) begin
                        state_d = ST_RESUME;
                    end
                end else if (up_sop) begin
                    state_d = ST_BCAST;
                end else if (sop_hit != '0) begin
                    state_d = ST_UPSTR;
                end
            end
            ST_UPSTR: begin
                if (dn_eop[src_port_q] || cut_babble) begin
                    state_d = ST_IDLE;
                end
            end
            ST_BCAST: begin
                if (up_eop) begin
                    state_d = ST_IDLE;
                end
            end
            ST_RESUME: begin
                if (!up_resume && (rsm_src == '0)) begin
                    state_d = ST_IDLE;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n || bus_reset) begin
            state_q <= ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // source port latched at the start of an upstream connection
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            src_port_q <= '0;
        end else if (state_q == ST_IDLE && state_d == ST_UPSTR) begin
            src_port_q <= sop_idx;
        end
    end

    // ------------------------------------------------------------
    // drive enables
    // ------------------------------------------------------------

    // drive masks are recomputed every cycle so a port disabled mid
    // packet stops driving at once
    always_ff @(posedge clk) begin
        if (!rst_n || bus_reset) begin
            up_drive_q <= 1'b0;
            dn_drive_q <= '0;
        end else begin
            case (state_d)
                ST_UPSTR: begin
                    up_drive_q <= 1'b1;
                    dn_drive_q <= '0;
                end
                ST_BCAST: begin
                    up_drive_q <= 1'b0;
                    dn_drive_q <= rpt_live;
                end
                ST_RESUME: begin
                    up_drive_q <= (rsm_src != '0);
                    dn_drive_q <= live_mask;
                end
                default: begin
                    up_drive_q <= 1'b0;
                    dn_drive_q <= '0;
                end
            endcase
        end
    end

    // receive mode is the complement of drive on every port
    always_ff @(posedge clk) begin
        if (!rst_n || bus_reset) begin
            up_rx_mode_q <= 1'b1;
            dn_rx_mode_q <= '1;
        end else begin
            case (state_d)
                ST_UPSTR: begin
                    up_rx_mode_q <= 1'b0;
                    dn_rx_mode_q <= '1;
                end
                ST_BCAST: begin
                    up_rx_mode_q <= 1'b1;
                    dn_rx_mode_q <= ~rpt_live;
                end
                ST_RESUME: begin
                    up_rx_mode_q <= (rsm_src == '0);
                    dn_rx_mode_q <= ~live_mask;
                end
                default: begin
                    up_rx_mode_q <= 1'b1;
                    dn_rx_mode_q <= '1;
                end
            endcase
        end
    end

    // state bits brought out for observation
    always_ff @(posedge clk) begin
        if (!rst_n || bus_reset) begin
            conn_state_q <= ST_IDLE;
        end else begin
            conn_state_q <= state_d;
        end
    end

    // ------------------------------------------------------------
    // fault handling
    // ------------------------------------------------------------

    // babble flag per port: set at end of frame while still sending,
    // cleared when software disables the port; the set wins
    always_ff @(posedge clk) begin
        if (!rst_n || bus_reset) begin
            babble_q <= '0;
        end else begin
            for (int i = 0; i < NPORTS; i++) begin
                if (cut_babble && (src_port_q == PIDX_W'(i))) begin
                    babble_q[i] <= 1'b1;
                end else if (!dn_enabled[i]) begin
                    babble_q[i] <= 1'b0;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // hub controller reply timeout
    // ------------------------------------------------------------

    // counts bit times while the controller waits; fires once, then
    // stays quiet until the wait is withdrawn, a packet arrives or the bus is reset
    always_ff @(posedge clk) begin
        if (!rst_n || bus_reset || !ctrl_wait || ctrl_pkt_rx) begin
            ctrl_cnt_q <= 16'h0000;
            ctrl_armed_q <= 1'b1;
            ctrl_timeout_q <= 1'b0;
        end else if (bit_tick && ctrl_armed_q) begin
            if (ctrl_cnt_q >= CTRL_TIMEOUT_BITS - 16'h0001) begin
                ctrl_timeout_q <= 1'b1;
                ctrl_armed_q <= 1'b0;
            end else begin
                ctrl_cnt_q <= ctrl_cnt_q + 16'h0001;
                ctrl_timeout_q <= 1'b0;
            end
        end else begin
            ctrl_timeout_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // frame timer
    // ------------------------------------------------------------

    frame_timer u_frame_timer (
        .clk(clk),
        .rst_n(rst_n),
        .resync(resync),
        .bit_tick(bit_tick),
        .sof_det(sof_det),
        .hs_mode(hs_mode_q),
        .locked_q(frame_locked_q),
        .eof_q(eof_q)
    );

endmodule // hub_route_top

// file: hw/hub_route_pkg.sv
package hub_route_pkg;

    localparam int NPORTS = 4;
    localparam int PIDX_W = 2;

    // period window and nominal values in bit times
    localparam logic [15:0] HS_PERIOD_MIN = 16'hEA00;
    localparam logic [15:0] HS_PERIOD_MAX = 16'hEAC0;
    localparam logic [15:0] HS_PERIOD_NOM = 16'hEA60;
    localparam logic [15:0] FS_PERIOD_MIN = 16'h2EB6;
    localparam logic [15:0] FS_PERIOD_MAX = 16'h2F0A;
    localparam logic [15:0] FS_PERIOD_NOM = 16'h2EE0;
    // rollover test points of the running counter
    localparam logic [15:0] HS_ROLL = 16'hFFFF;
    localparam logic [15:0] FS_ROLL = 16'h3FFF;

    // hub controller reply timeout, in bit times
    localparam logic [15:0] CTRL_TIMEOUT_BITS = 16'h0012;

    typedef enum logic [3:0] {
        ST_IDLE   = 4'h1,
        ST_UPSTR  = 4'h2,
        ST_BCAST  = 4'h4,
        ST_RESUME = 4'h8
    } conn_state_e;

endpackage

// file: hw/frame_timer.sv
`timescale 1ns/1ps
module frame_timer (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic resync,
    input wire logic bit_tick,
    input wire logic sof_det,
    input wire logic hs_mode,
    output logic locked_q,
    output logic eof_q
);
    import hub_route_pkg::*;

    logic [15:0] cur_q;
    logic [15:0] tmr_q;
    logic [15:0] next_q;
    logic rolled_q;
    logic good_sof;
    logic [15:0] roll_lim;

    // period window check, one place for both speeds
    function automatic logic in_window(input logic [15:0] v, input logic hs);
        if (hs) begin
            in_window = (v >= HS_PERIOD_MIN) && (v <= HS_PERIOD_MAX);
        end else begin
            in_window = (v >= FS_PERIOD_MIN) && (v <= FS_PERIOD_MAX);
        end
    endfunction

    assign roll_lim = hs_mode ? HS_ROLL : FS_ROLL;
    // an SOF only counts if it arrives inside the window after the previous one
    assign good_sof = sof_det && !rolled_q && in_window(cur_q, hs_mode);

    // running up counter; starts rolled so the first SOF only arms it
    always_ff @(posedge clk) begin
        if (!rst_n || resync) begin
            cur_q <= 16'h0000;
            rolled_q <= 1'b1;
        end else if (sof_det) begin
            cur_q <= 16'h0000;
            rolled_q <= 1'b0;
        end else if (bit_tick && !rolled_q) begin
            if (cur_q >= roll_lim) begin
                rolled_q <= 1'b1;
            end else begin
                cur_q <= cur_q + 16'h0001;
            end
        end
    end

    // down counter and period register; a missed SOF reuses the old period
    always_ff @(posedge clk) begin
        if (!rst_n || resync) begin
            tmr_q <= 16'h0000;
            next_q <= 16'h0000;
        end else if (good_sof) begin
            tmr_q <= cur_q;
            next_q <= cur_q;
        end else if (sof_det && locked_q) begin
            tmr_q <= next_q;
        end else if (bit_tick && locked_q) begin
            if (tmr_q == 16'h0000) begin
                tmr_q <= next_q;
            end else begin
                tmr_q <= tmr_q - 16'h0001;
            end
        end
    end

    // lock flag: set by two consecutive SOFs, kept through missed ones
    always_ff @(posedge clk) begin
        if (!rst_n || resync) begin
            locked_q <= 1'b0;
        end else if (good_sof) begin
            locked_q <= 1'b1;
        end
    end

    // one-cycle end-of-frame mark when the down counter hits zero
    always_ff @(posedge clk) begin
        if (!rst_n || resync) begin
            eof_q <= 1'b0;
        end else begin
            eof_q <= bit_tick && locked_q && (tmr_q == 16'h0000);
        end
    end

endmodule // frame_timer

// file: tb/hub_route_monitor.sv
`timescale 1ns/1ps
// ----
// checker on the routing block ports
// ----
module hub_route_monitor (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic bus_reset,
    input wire logic up_hs_conn,
    input wire logic sof_det,
    input wire logic hub_suspended,
    input wire logic up_sop,
    input wire logic up_eop,
    input wire logic up_resume,
    input wire logic [hub_route_pkg::NPORTS-1:0] dn_connected,
    input wire logic [hub_route_pkg::NPORTS-1:0] dn_hs_dev,
    input wire logic [hub_route_pkg::NPORTS-1:0] dn_enabled,
    input wire logic [hub_route_pkg::NPORTS-1:0] dn_suspended,
    input wire logic [hub_route_pkg::NPORTS-1:0] dn_sop,
    input wire logic [hub_route_pkg::NPORTS-1:0] dn_resume,
    input wire logic hs_mode_q,
    input wire logic hs_rpt_en_q,
    input wire logic fs_rpt_en_q,
    input wire logic tt_en_q,
    input wire logic [hub_route_pkg::NPORTS-1:0] route_tt_q,
    input wire logic [hub_route_pkg::NPORTS-1:0] route_rpt_q,
    input wire logic up_drive_q,
    input wire logic [hub_route_pkg::NPORTS-1:0] dn_drive_q,
    input wire logic up_rx_mode_q,
    input wire logic [hub_route_pkg::NPORTS-1:0] dn_rx_mode_q,
    input wire logic [3:0] conn_state_q,
    input wire logic [hub_route_pkg::PIDX_W-1:0] src_port_q,
    input wire logic frame_locked_q,
    input wire logic eof_q,
    input wire logic [hub_route_pkg::NPORTS-1:0] babble_q
);
    import hub_route_pkg::*;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    // routes lag inputs by one cycle, so the first cycle after reset is skipped
    sequence s_bcast_go;
        conn_state_q == ST_IDLE && up_sop && !hub_suspended && !bus_reset;
    endsequence
    sequence s_resume_go;
        conn_state_q == ST_IDLE && hub_suspended && !bus_reset && dn_sop == 4'h0
            && (up_resume || (dn_resume & dn_enabled) != 4'h0);
    endsequence
    a_hs_mode_paths: assert property (hs_mode_q |-> tt_en_q && hs_rpt_en_q && !fs_rpt_en_q)
        else $error("hs mode paths wrong");
    a_fs_no_tt: assert property (!hs_mode_q |-> fs_rpt_en_q && !tt_en_q && route_tt_q == 4'h0)
        else $error("fs mode paths wrong");
    a_tt_route: assert property ($past(rst_n) && $past(up_hs_conn) |->
        route_tt_q == $past(dn_connected & ~dn_hs_dev)) else $error("tt route wrong");
    a_rpt_route: assert property ($past(rst_n) && $past(up_hs_conn) |->
        route_rpt_q == $past(dn_connected & dn_hs_dev)) else $error("rpt route wrong");
    a_idle_quiet: assert property (conn_state_q == ST_IDLE |-> !up_drive_q
        && dn_drive_q == 4'h0 && up_rx_mode_q && dn_rx_mode_q == 4'hF) else $error("idle drives");
    a_upstr_only: assert property (conn_state_q == ST_UPSTR |-> up_drive_q && dn_drive_q == 4'h0)
        else $error("upstream connection drives downstream");
    a_bcast_start: assert property (s_bcast_go |=> conn_state_q == ST_BCAST)
        else $error("no broadcast");
    a_no_drive_off: assert property ($past(rst_n) |-> (dn_drive_q & ~$past(dn_enabled)) == 4'h0)
        else $error("disabled port driven");
    a_resume_enter: assert property (s_resume_go |=> conn_state_q == ST_RESUME)
        else $error("resume not entered");
    a_resume_skip: assert property (conn_state_q == ST_RESUME && $past(rst_n) |->
        (dn_drive_q & $past(dn_suspended)) == 4'h0) else $error("suspended port resumed");
    a_bcast_end: assert property (conn_state_q == ST_BCAST && up_eop && !bus_reset |=>
        conn_state_q == ST_IDLE) else $error("broadcast held past end");
    a_babble_cut: assert property (conn_state_q == ST_UPSTR && eof_q && !bus_reset
        && route_rpt_q[src_port_q] |=> conn_state_q == ST_IDLE && babble_q[$past(src_port_q)])
        else $error("babble not cut");
    a_lock_on_sof: assert property ($rose(frame_locked_q) |-> $past(sof_det))
        else $error("lock without sof");
endmodule // hub_route_monitor

// file: tb/sof_source.sv
`timescale 1ns/1ps
// ----
// host side: bit time ticks and sof tokens
// ----
module sof_source #(
    parameter int PERIOD = 12000
) (
    input wire logic clk,
    input wire logic run,
    input wire logic skip,
    output logic bit_tick,
    output logic sof_det
);
    int cnt_q;
    initial begin
        bit_tick = 1'b0;
        sof_det = 1'b0;
        cnt_q = 0;
    end
    // one tick a clock; skip drops tokens but keeps the host period running
    always @(negedge clk) begin
        bit_tick <= run;
        sof_det <= 1'b0;
        if (!run) begin
            cnt_q <= 0;
        end else if (cnt_q == PERIOD - 1) begin
            cnt_q <= 0;
            sof_det <= !skip;
        end else begin
            cnt_q <= cnt_q + 1;
        end
    end
endmodule // sof_source

// file: tb/hub_route_top_test.sv
`timescale 1ns/1ps
// ----
// bench for hub routing and connectivity
// ----
module hub_route_top_test;
    import hub_route_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, bus_reset = 1'b0, resume_done = 1'b0, up_hs_conn = 1'b0;
    logic hub_suspended = 1'b0, up_sop = 1'b0, up_eop = 1'b0, up_resume = 1'b0;
    logic ctrl_wait = 1'b0, ctrl_pkt_rx = 1'b0, run = 1'b0, skip = 1'b0;
    logic [NPORTS-1:0] dn_connected = 4'h0, dn_hs_dev = 4'h0, dn_enabled = 4'h0;
    logic [NPORTS-1:0] dn_suspended = 4'h0, dn_sop = 4'h0, dn_eop = 4'h0, dn_resume = 4'h0;
    logic bit_tick, sof_det, hs_mode_q, hs_rpt_en_q, fs_rpt_en_q, tt_en_q, up_drive_q;
    logic up_rx_mode_q, frame_locked_q, eof_q, ctrl_timeout_q;
    logic [NPORTS-1:0] route_tt_q, route_rpt_q, dn_drive_q, dn_rx_mode_q, babble_q;
    logic [3:0] conn_state_q;
    logic [PIDX_W-1:0] src_port_q;
    int n_errors = 0, compares = 0, cycles = 0;
    hub_route_top i_dut (.*);
    sof_source #(.PERIOD(12000)) i_host (.clk(clk), .run(run), .skip(skip),
        .bit_tick(bit_tick), .sof_det(sof_det));
    initial begin
        forever #25 clk = ~clk;
    end
    // hang guard: whole run needs about 60k cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 90000) begin
            n_errors++;
            print_verdict();
        end
    end
    task automatic print_verdict();
        if (n_errors == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk(string nm, logic [15:0] exp, logic [15:0] got);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic step(int n);
        repeat (n) @(negedge clk);
    endtask
    // speed choice and per-port routing, both upstream speeds
    task automatic t_speed();
        dn_connected = 4'hF;
        dn_hs_dev = 4'h5;
        step(2);
        chk("fs_mode", 1'b0, hs_mode_q);
        chk("fs_rpt", 3'b001, {tt_en_q, hs_rpt_en_q, fs_rpt_en_q});
        chk("fs_route", 8'hF0, {route_rpt_q, route_tt_q});
        up_hs_conn = 1'b1;
        step(2);
        chk("hs_mode", 4'hE, {hs_mode_q, tt_en_q, hs_rpt_en_q, fs_rpt_en_q});
        chk("hs_tt", 4'hA, route_tt_q);
        chk("hs_rpt", 4'h5, route_rpt_q);
        up_hs_conn = 1'b0;
        dn_hs_dev = 4'h0;
        step(2);
    endtask
    // upstream connection, refused start on a disabled port, hold until own end
    task automatic t_upstr();
        chk("idle", 14'h041F, {conn_state_q, up_drive_q, dn_drive_q, up_rx_mode_q, dn_rx_mode_q});
        dn_enabled = 4'hB;
        dn_sop = 4'h4;
        step(1);
        chk("sop_off", 4'h1, conn_state_q);
        dn_enabled = 4'hF;
        step(1);
        dn_sop = 4'h0;
        chk("upstr", 8'h2A, {conn_state_q, src_port_q, up_drive_q, up_rx_mode_q});
        chk("upstr_dn", 4'h0, dn_drive_q);
        up_sop = 1'b1;
        dn_eop = 4'h1;
        step(1);
        up_sop = 1'b0;
        dn_eop = 4'h4;
        chk("upstr_hold", 4'h2, conn_state_q);
        step(1);
        dn_eop = 4'h0;
        chk("upstr_end", 4'h1, conn_state_q);
    endtask
    // broadcast reaches enabled, unsuspended ports only
    task automatic t_bcast();
        dn_enabled = 4'hB;
        dn_suspended = 4'h2;
        up_sop = 1'b1;
        step(1);
        up_sop = 1'b0;
        chk("bcast", 4'h4, conn_state_q);
        chk("bcast_mask", 8'h96, {dn_drive_q, dn_rx_mode_q});
        up_eop = 1'b1;
        step(1);
        up_eop = 1'b0;
        chk("bcast_end", 8'h10, {conn_state_q, dn_drive_q});
    endtask
    // resume from a suspended and an enabled port, then from upstream
    task automatic t_resume();
        hub_suspended = 1'b1;
        dn_enabled = 4'h7;
        dn_suspended = 4'h4;
        dn_resume = 4'h5;
        step(2);
        chk("res_dn", 9'h113, {conn_state_q, up_drive_q, dn_drive_q});
        dn_resume = 4'h0;
        up_resume = 1'b1;
        step(2);
        chk("res_up", 9'h103, {conn_state_q, up_drive_q, dn_drive_q});
        up_resume = 1'b0;
        step(2);
        chk("res_end", 4'h1, conn_state_q);
        hub_suspended = 1'b0;
        dn_enabled = 4'hF;
        dn_suspended = 4'h0;
    endtask
    task automatic wait_sof();
        while (sof_det !== 1'b1) step(1);
    endtask
    // lock, control timeout, missed tokens, babble cut, resync on resume
    task automatic t_timer();
        int n;
        int first;
        bus_reset = 1'b1;
        step(1);
        bus_reset = 1'b0;
        run = 1'b1;
        wait_sof();
        step(2);
        chk("lock_first", 1'b0, frame_locked_q);
        wait_sof();
        step(2);
        chk("lock_second", 1'b1, frame_locked_q);
        // a packet after five ticks restarts the count, so the pulse lands 18 ticks later
        ctrl_wait = 1'b1;
        first = 0;
        n = 0;
        for (int k = 1; k <= 40; k++) begin
            step(1);
            ctrl_pkt_rx = (k == 5);
            if (ctrl_timeout_q === 1'b1) begin
                n++;
                if (first == 0) first = k;
            end
        end
        ctrl_wait = 1'b0;
        chk("ctrl_to", 16'h0018, 16'(first));
        chk("ctrl_once", 16'h0001, 16'(n));
        skip = 1'b1;
        n = 0;
        repeat (30000) begin
            step(1);
            if (eof_q === 1'b1) n++;
        end
        skip = 1'b0;
        chk("lock_kept", 1'b1, frame_locked_q);
        chk("eof_free", 1'b1, n >= 2 && n <= 3);
        dn_sop = 4'h1;
        step(1);
        dn_sop = 4'h0;
        chk("babble_conn", 4'h2, conn_state_q);
        while (eof_q !== 1'b1) step(1);
        step(1);
        chk("babble_cut", 8'h11, {conn_state_q, babble_q});
        dn_enabled = 4'hE;
        step(2);
        chk("babble_clr", 4'h0, babble_q);
        resume_done = 1'b1;
        step(1);
        resume_done = 1'b0;
        step(1);
        chk("lock_resume", 1'b0, frame_locked_q);
    endtask
    initial begin
        repeat (20) @(negedge clk);
        rst_n = 1'b1;
        step(1);
        t_speed();
        t_upstr();
        t_bcast();
        t_resume();
        t_timer();
        print_verdict();
    end
endmodule // hub_route_top_test
bind hub_route_top hub_route_monitor i_mon (.*);
